// ==== logic/eeprom_array.sv ====
// Byte-wide storage array with registered read data
`default_nettype none
module eeprom_array #(
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    if (DEPTH != (1 << AW)) begin : g_depth_check
        $error("eeprom_array: DEPTH must equal 2**AW");
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ==== logic/eeprom_ctrl.sv ====
// Data EEPROM controller reached through three special function registers
//
// Overview of operation
// - Mode field picks byte, row or array fill
// - Array address is upper bit plus address register
// - Data write then address write starts program
// - Lone address write reads; data after three machine cycles (six clocks)
// - Every program or fill takes about 4 ms
// - Row fill writes all 64 row bytes
// - Completion sets flag bit 7; software clears
// - Interrupt when flag and both enables set
// - Program under low supply blocked, bit 2 set
// - Supply low mid-program sets bit 1
// - Supply error flags cleared by reset or write
// - Programming voltage fault reported in bit 6
// - Hardware reset forgets pending data write
// - Latest data write is the one programmed
// - Data write arms program only in byte mode
`default_nettype none
module eeprom_ctrl
    import eeprom_ctrl_pkg::*;
#(
    parameter int PROGRAM_CYCLE_COUNT = PROGRAM_CYCLES,
    parameter int READ_CYCLE_COUNT = READ_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic SUPPLY_LOW,
    input wire logic HV_FAULT,
    input wire logic EEPROM_INT_ENABLE,
    input wire logic GLOBAL_INT_ENABLE,
    output logic IRQ,
    output logic BUSY
);
    import eeprom_ctrl_pkg::*;

    if (PROGRAM_CYCLE_COUNT < 1 || READ_CYCLE_COUNT < 1 || READ_CYCLE_COUNT > 255)
    begin : g_count_check
        $error("eeprom_ctrl: cycle counts out of range");
    end

    typedef enum logic [1:0] {IDLE, READING, PROGRAMMING} state_e;

    // ************************************************************
    // Registers
    // ************************************************************
    state_e state_ff, nxt_state;
    logic [7:0] control_ff, nxt_control;
    logic [7:0] addr_low_ff;
    logic [7:0] data_ff, nxt_data;
    logic pending_ff, nxt_pending;
    logic [1:0] op_mode_ff;
    logic [ADDR_WIDTH-1:0] op_addr_ff, nxt_op_addr;
    logic [ADDR_WIDTH-1:0] fill_idx_ff;
    logic [31:0] timer_ff, nxt_timer;

    // ************************************************************
    // Decode
    // ************************************************************
    wire wr_control = SFR_WR && (SFR_ADDR == ADDR_CONTROL_STATUS);
    wire wr_addr = SFR_WR && (SFR_ADDR == ADDR_ADDRESS_LOW);
    wire wr_data = SFR_WR && (SFR_ADDR == ADDR_DATA);
    wire idle = (state_ff == IDLE);
    wire [1:0] mode = control_ff[BIT_MODE_HIGH:BIT_MODE_LOW];
    wire start = wr_addr && idle;
    wire [ADDR_WIDTH-1:0] req_addr = {control_ff[BIT_UPPER_ADDR], SFR_WDATA};
    wire byte_read_req = start && (mode == MODE_BYTE) && !pending_ff;
    wire byte_prog_req = start && (mode == MODE_BYTE) && pending_ff;
    wire fill_req = start && ((mode == MODE_ROW_FILL) || (mode == MODE_ARRAY_FILL));
    wire prog_req = byte_prog_req || fill_req;
    wire blocked = prog_req && SUPPLY_LOW;
    wire programming = (state_ff == PROGRAMMING);
    wire timer_done = (timer_ff == 32'h0);

    // Fill walks one byte per clock; a row fill stops after 64 bytes, array fill wraps and rewrites for the whole 4 ms window
    wire [ADDR_WIDTH-1:0] fill_span = (op_mode_ff == MODE_ARRAY_FILL) ?
        ADDR_WIDTH'(ARRAY_BYTES - 1) : ADDR_WIDTH'(ROW_BYTES - 1);
    wire fill_active = programming && (op_mode_ff != MODE_BYTE) && (fill_idx_ff <= fill_span);
    wire [ADDR_WIDTH-1:0] row_base = {op_addr_ff[ADDR_WIDTH-1:ROW_BITS], {ROW_BITS{1'b0}}};
    wire [ADDR_WIDTH-1:0] fill_addr = (op_mode_ff == MODE_ARRAY_FILL) ?
        fill_idx_ff : (row_base | fill_idx_ff);
    wire byte_write = programming && (op_mode_ff == MODE_BYTE) && timer_done;
    wire mem_wr = fill_active || byte_write;
    wire [ADDR_WIDTH-1:0] mem_wr_addr = fill_active ? fill_addr : op_addr_ff;
    wire [7:0] mem_rd_data;
    wire op_done = !idle && timer_done;

    eeprom_array #(
        .DEPTH(ARRAY_BYTES),
        .AW(ADDR_WIDTH)
    ) u_array (
        .clk(MCLK),
        .wr_en(mem_wr),
        .wr_addr(mem_wr_addr),
        .wr_data(data_ff),
        .rd_addr(op_addr_ff),
        .rd_data(mem_rd_data)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_op_addr = op_addr_ff;
        case (state_ff)
            IDLE: begin
                if (byte_read_req) begin
                    nxt_state = READING;
                    nxt_op_addr = req_addr;
                    nxt_timer = 32'(READ_CYCLE_COUNT - 1);
                end else if (prog_req && !blocked) begin
                    nxt_state = PROGRAMMING;
                    nxt_op_addr = req_addr;
                    nxt_timer = 32'(PROGRAM_CYCLE_COUNT - 1);
                end
            end
            READING, PROGRAMMING: begin
                if (timer_done) begin
                    nxt_state = IDLE;
                end else begin
                    nxt_timer = timer_ff - 32'h1;
                end
            end
            default: nxt_state = IDLE;
        endcase
    end

    // Data register: read result lands at completion, software write otherwise
    always_comb begin
        nxt_data = data_ff;
        if (state_ff == READING && timer_done) begin
            nxt_data = mem_rd_data;
        end else if (wr_data) begin
            nxt_data = SFR_WDATA;
        end
    end

    always_comb begin
        nxt_pending = pending_ff;
        if (wr_data && (mode == MODE_BYTE)) begin
            nxt_pending = 1'b1;
        end else if (start && (mode == MODE_BYTE)) begin
            nxt_pending = 1'b0;
        end
    end

    always_comb begin
        nxt_control = control_ff;
        if (wr_control) begin
            // Software write clears both supply flags and the HV flag (bit 6 not in write mask); completion flag writable to clear
            nxt_control = SFR_WDATA & CONTROL_WRITE_MASK;
            nxt_control[BIT_REQUEST_ERR] = 1'b0;
            nxt_control[BIT_IN_PROGRESS_ERR] = 1'b0;
        end
        if (blocked) begin
            nxt_control[BIT_REQUEST_ERR] = 1'b1;
        end
        if (programming && SUPPLY_LOW) begin
            nxt_control[BIT_IN_PROGRESS_ERR] = 1'b1;
        end
        if (programming && HV_FAULT) begin
            nxt_control[BIT_HIGH_VOLTAGE_ERR] = 1'b1;
        end
        if (op_done) begin
            nxt_control[BIT_COMPLETION] = 1'b1;
        end
    end

    // ************************************************************
    // State registers
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_ff <= IDLE;
            control_ff <= CONTROL_RESET;
            addr_low_ff <= 8'h00;
            data_ff <= 8'h00;
            pending_ff <= 1'b0;
            op_mode_ff <= MODE_BYTE;
            op_addr_ff <= '0;
            fill_idx_ff <= '0;
            timer_ff <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            control_ff <= nxt_control;
            data_ff <= nxt_data;
            pending_ff <= nxt_pending;
            op_addr_ff <= nxt_op_addr;
            timer_ff <= nxt_timer;
            if (wr_addr) begin
                addr_low_ff <= SFR_WDATA;
            end
            if (start) begin
                op_mode_ff <= mode;
                fill_idx_ff <= '0;
            end else if (fill_active) begin
                fill_idx_ff <= fill_idx_ff + ADDR_WIDTH'(1);
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb begin
        SFR_RDATA = 8'h00;
        if (SFR_RD) begin
            case (SFR_ADDR)
                ADDR_CONTROL_STATUS: SFR_RDATA = control_ff;
                ADDR_ADDRESS_LOW: SFR_RDATA = addr_low_ff;
                ADDR_DATA: SFR_RDATA = data_ff;
                default: SFR_RDATA = 8'h00;
            endcase
        end
    end

    assign IRQ = control_ff[BIT_COMPLETION] && EEPROM_INT_ENABLE && GLOBAL_INT_ENABLE;
    assign BUSY = !idle;
endmodule
`default_nettype wire

// ==== logic/eeprom_ctrl_pkg.sv ====
// Constants shared by the data EEPROM controller and its array
`default_nettype none
package eeprom_ctrl_pkg;
    // ************************************************************
    // Register offsets (SFR space)
    // ************************************************************
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'hf1;
    localparam logic [7:0] ADDR_ADDRESS_LOW = 8'hf2;
    localparam logic [7:0] ADDR_DATA = 8'hf3;
    // ************************************************************
    // Control/status field positions and reset value
    // ************************************************************
    localparam int BIT_UPPER_ADDR = 0;
    localparam int BIT_IN_PROGRESS_ERR = 1;
    localparam int BIT_REQUEST_ERR = 2;
    localparam int BIT_MODE_LOW = 4;
    localparam int BIT_MODE_HIGH = 5;
    localparam int BIT_HIGH_VOLTAGE_ERR = 6;
    localparam int BIT_COMPLETION = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hb7;
    // ************************************************************
    // Operation modes
    // ************************************************************
    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_ROW_FILL = 2'h2;
    localparam logic [1:0] MODE_ARRAY_FILL = 2'h3;
    // ************************************************************
    // Geometry and timing
    // ************************************************************
    localparam int ARRAY_BYTES = 512;
    localparam int ADDR_WIDTH = 9;
    localparam int ROW_BYTES = 64;
    localparam int ROW_BITS = 6;
    localparam int CLOCK_MHZ = 250;
    localparam int PROGRAM_TIME_US = 4000;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ;
    localparam int READ_MACHINE_CYCLES = 3;
    localparam int CLOCKS_PER_MACHINE_CYCLE = 2;
    localparam int READ_CYCLES = READ_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE;
endpackage
`default_nettype wire

// ==== verification/eeprom_ctrl_properties.sv ====
// Port-level assertions for the data EEPROM controller
`default_nettype none
module eeprom_ctrl_properties
    import eeprom_ctrl_pkg::*;
#(
    parameter int PROGRAM_CYCLE_COUNT = PROGRAM_CYCLES,
    parameter int READ_CYCLE_COUNT = READ_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SUPPLY_LOW,
    input wire logic HV_FAULT,
    input wire logic EEPROM_INT_ENABLE,
    input wire logic GLOBAL_INT_ENABLE,
    input wire logic IRQ,
    input wire logic BUSY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Length of the current busy stretch, so read and program times are exact
    logic [31:0] busy_cnt_ff;
    always_ff @(posedge MCLK) begin
        busy_cnt_ff <= (RST || !BUSY) ? 32'h0 : busy_cnt_ff + 32'h1;
    end
    wire ctl_rd = SFR_RD && SFR_ADDR == ADDR_CONTROL_STATUS;
    wire ctl_wr = SFR_WR && SFR_ADDR == ADDR_CONTROL_STATUS;
    wire both_en = EEPROM_INT_ENABLE && GLOBAL_INT_ENABLE;
    sequence s_busy_rise;
        !BUSY ##1 BUSY;
    endsequence
    sequence s_busy_end;
        $fell(BUSY);
    endsequence
    property p_start;
        s_busy_rise |-> $past(SFR_WR && SFR_ADDR == ADDR_ADDRESS_LOW);
    endproperty
    property p_busy_len;
        s_busy_end |-> busy_cnt_ff == READ_CYCLE_COUNT || busy_cnt_ff == PROGRAM_CYCLE_COUNT;
    endproperty
    property p_irq_flag;
        ctl_rd |-> IRQ == (SFR_RDATA[BIT_COMPLETION] && both_en);
    endproperty
    property p_irq_mask;
        !both_en |-> !IRQ;
    endproperty
    property p_flag_sticky;
        IRQ && !ctl_wr ##1 both_en |-> IRQ;
    endproperty
    property p_rd_idle;
        !SFR_RD |-> SFR_RDATA == 8'h00;
    endproperty
    property p_rd_unmapped;
        SFR_RD && (SFR_ADDR < ADDR_CONTROL_STATUS || SFR_ADDR > ADDR_DATA) |-> SFR_RDATA == 8'h00;
    endproperty
    property p_rsv_bit;
        ctl_rd |-> !SFR_RDATA[3];
    endproperty
    property p_reset_clear;
        $fell(RST) |-> !BUSY && !IRQ;
    endproperty
    a_start: assert property (p_start) else $error("busy rose without address write");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    a_irq_flag: assert property (p_irq_flag) else $error("irq differs from flag");
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
    a_rd_idle: assert property (p_rd_idle) else $error("read data while idle");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
    a_rsv_bit: assert property (p_rsv_bit) else $error("reserved bit set");
    a_reset_clear: assert property (p_reset_clear) else $error("reset left activity");
endmodule
bind eeprom_ctrl eeprom_ctrl_properties #(.PROGRAM_CYCLE_COUNT(PROGRAM_CYCLE_COUNT),
    .READ_CYCLE_COUNT(READ_CYCLE_COUNT)) props_i (.MCLK(MCLK), .RST(RST),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA), .SUPPLY_LOW(SUPPLY_LOW), .HV_FAULT(HV_FAULT),
    .EEPROM_INT_ENABLE(EEPROM_INT_ENABLE), .GLOBAL_INT_ENABLE(GLOBAL_INT_ENABLE),
    .IRQ(IRQ), .BUSY(BUSY));
`default_nettype wire

// ==== verification/eeprom_ctrl_tb.sv ====
// Self-checking bench for the data EEPROM controller
`default_nettype none
module eeprom_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import eeprom_ctrl_pkg::*;
    // Starts low so time zero brings no false falling edge
    logic mclk = 1'b0;
    logic rst, supply_low, hv_fault, ien, gen;
    wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    wire logic sfr_wr, sfr_rd, irq, busy;
    logic [7:0] exp_q[$];
    logic [7:0] a, d, p;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 32'ha2319110;
    sfr_core_model core_i (.mclk(mclk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
    eeprom_ctrl #(.PROGRAM_CYCLE_COUNT(600), .READ_CYCLE_COUNT(6)) eeprom_ctrl_i (
        .MCLK(mclk), .RST(rst), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
        .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .SUPPLY_LOW(supply_low),
        .HV_FAULT(hv_fault), .EEPROM_INT_ENABLE(ien), .GLOBAL_INT_ENABLE(gen),
        .IRQ(irq), .BUSY(busy));
    task automatic results;
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] e);
        total_checks++;
        if (sfr_rdata !== e) begin
            num_errors++;
            $display("wrong value at %0t: read %h expected %h", $time, sfr_rdata, e);
        end
    endtask
    task automatic chk_bit(input logic v, input logic e);
        total_checks++;
        if (v !== e) begin
            num_errors++;
            $display("wrong value at %0t: pin %b expected %b", $time, v, e);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        core_i.access(1'b1, ad, dt);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        core_i.access(1'b0, ad, 8'h00);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (2) @(negedge mclk);
        while (busy !== 1'b0 && n < 2000) begin
            n++;
            @(negedge mclk);
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (sfr_rd === 1'b1) begin
            chk(exp_q.pop_front());
        end
        cycles++;
        // Generous ceiling: four programs of 600 cycles plus reads
        if (cycles == 30000) begin
            num_errors++;
            results;
        end
    end
    initial begin
        {rst, supply_low, hv_fault, ien, gen} = 5'h10;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        rd(ADDR_CONTROL_STATUS, CONTROL_RESET);
        rd(8'hf0, 8'h00);
        d = 8'($random(seed));
        a = 8'($random(seed));
        wr(ADDR_CONTROL_STATUS, 8'h00);
        wr(ADDR_DATA, ~d);
        wr(ADDR_DATA, d);
        wr(ADDR_ADDRESS_LOW, a);
        chk_bit(busy, 1'b1);
        gen = 1'b1;
        ien = 1'b1;
        wr(ADDR_ADDRESS_LOW, ~a);
        wait_idle;
        chk_bit(irq, 1'b1);
        rd(ADDR_CONTROL_STATUS, 8'h80);
        wr(ADDR_CONTROL_STATUS, 8'h00);
        wr(ADDR_ADDRESS_LOW, a);
        wait_idle;
        rd(ADDR_DATA, d);
        p = 8'($random(seed));
        wr(ADDR_CONTROL_STATUS, 8'h20);
        wr(ADDR_DATA, p);
        wr(ADDR_ADDRESS_LOW, a);
        wait_idle;
        wr(ADDR_CONTROL_STATUS, 8'h00);
        wr(ADDR_ADDRESS_LOW, {a[7:6], ~a[5:0]});
        wait_idle;
        rd(ADDR_DATA, p);
        ien = 1'($random(seed));
        wr(ADDR_CONTROL_STATUS, 8'h10);
        wr(ADDR_DATA, d);
        wr(ADDR_ADDRESS_LOW, a);
        chk_bit(busy, 1'b0);
        wait_idle;
        rd(ADDR_CONTROL_STATUS, 8'h10);
        wr(ADDR_CONTROL_STATUS, 8'h31);
        wr(ADDR_DATA, ~p);
        wr(ADDR_ADDRESS_LOW, ~a);
        wait_idle;
        rd(ADDR_CONTROL_STATUS, 8'hb1);
        wr(ADDR_CONTROL_STATUS, 8'h00);
        wr(ADDR_ADDRESS_LOW, 8'h05);
        wait_idle;
        rd(ADDR_DATA, ~p);
        wr(ADDR_DATA, d);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        wr(ADDR_ADDRESS_LOW, 8'h05);
        wait_idle;
        rd(ADDR_DATA, ~p);
        supply_low = 1'b1;
        wr(ADDR_DATA, d);
        wr(ADDR_ADDRESS_LOW, a);
        chk_bit(busy, 1'b0);
        wait_idle;
        // Completion flag of the read after reset is still standing
        rd(ADDR_CONTROL_STATUS, 8'h84);
        wr(ADDR_CONTROL_STATUS, 8'h00);
        rd(ADDR_CONTROL_STATUS, 8'h00);
        supply_low = 1'b0;
        wr(ADDR_DATA, d);
        wr(ADDR_ADDRESS_LOW, a);
        {supply_low, hv_fault} = 2'h3;
        repeat (4) @(negedge mclk);
        {supply_low, hv_fault} = 2'h0;
        wait_idle;
        rd(ADDR_CONTROL_STATUS, 8'hc2);
        @(negedge mclk);
        results;
    end
endmodule
`default_nettype wire

// ==== verification/sfr_core_model.sv ====
// Core-side model issuing one-cycle register accesses
`default_nettype none
module sfr_core_model (
    input wire logic mclk,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end
    // Idle bus shows inverted values so stale data never looks valid
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = wr;
        sfr_rd = !wr;
        @(negedge mclk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask
endmodule
`default_nettype wire
